// File: rtl/e1fr_regs.svh
// Register offsets, field positions and sizes of the E1 framer channel register bank.
`ifndef E1FR_REGS_SVH
`define E1FR_REGS_SVH
`define E1FR_ADDR_W 12
`define E1FR_SIG_BASE 12'h500
`define E1FR_SIG_LAST 12'h51F
`define E1FR_BUF0_PORT 12'h600
`define E1FR_BUF1_PORT 12'h700
`define E1FR_LCV_UPPER 12'h900
`define E1FR_LCV_LOWER 12'h901
`define E1FR_CTL_SELECT 12'h11B
`define E1FR_TX_COUNT_1 12'h114
`define E1FR_TX_COUNT_2 12'h144
`define E1FR_TX_COUNT_3 12'h154
`define E1FR_RX_COUNT_1 12'h115
`define E1FR_RX_COUNT_2 12'h145
`define E1FR_RX_COUNT_3 12'h155
`define E1FR_IRQ_STATUS 12'hB00
`define E1FR_IRQ_MASK 12'hB01
`define E1FR_BUF_BYTES 7'h60
`define E1FR_BUF_LAST 7'h5F
`define E1FR_FLAG_BIT 7
`define E1FR_NUM_CTL 3
`define E1FR_NUM_TS 32
`define E1FR_RESET_BYTE 8'h00
`endif

// File: rtl/e1fr_pkg.sv
// Types shared by the two ends of the E1 framer register bank.
package e1fr_pkg;
    // Host sequencer states, Gray coded along idle, upper read, lower read, done.
    typedef enum logic [1:0] {
        E1FR_IDLE = 2'h0,
        E1FR_RD_HI = 2'h1,
        E1FR_RD_LO = 2'h3,
        E1FR_DONE = 2'h2
    } e1fr_host_state_type;
    // One timeslot's signaling bits, A in bit 3 down to D in bit 0.
    typedef logic [3:0] e1fr_sig_type;
endpackage

// File: rtl/e1fr_bus_if.sv
// Register bus joining the host end and the framer channel end.
`timescale 1ns/100ps
interface e1fr_bus_if;
    logic [11:0] addr; // Register offset within the channel.
    logic [7:0] wdata; // Write data.
    logic wr; // One-cycle write strobe.
    logic rd; // One-cycle read strobe.
    logic [7:0] rdata; // Read data, valid the cycle after rd.
    logic irq; // Level interrupt from the channel.
    modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq);
    modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

// File: rtl/e1fr_channel.sv
// Framer channel end: signaling array, message buffers, violation counter, interrupts.
//
// Contract
// - Read-only signaling entry per timeslot 0..31.
// - Debounce updates after two equal superframes.
// - Debounce keeps entry when superframes differ.
// - Without debounce, entry follows every change.
// - Buffer zero is an 8-bit 96-byte port.
// - Every port access advances the byte pointer.
// - Buffer one is a second 96-byte port.
// - Select register routes buffers to one controller.
// - Transmit count bit 7 shows free buffer.
// - Written message is handed over for sending.
// - Received message raises interrupt, bit 7 names buffer.
// - Sixteen-bit violation count, upper byte here.
// - Reading the counter clears it.
// - Upper byte read first, then lower byte.
`timescale 1ns/100ps
`include "e1fr_regs.svh"
module e1fr_channel #(
    parameter int NUM_CTL = `E1FR_NUM_CTL,
    parameter int NUM_TS = `E1FR_NUM_TS
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register bus from the host.
    e1fr_bus_if.dev bus,
    // Receive signaling from the framer, one pulse per timeslot per superframe.
    input wire logic i_sig_valid,
    input wire logic [4:0] i_sig_ts,
    input wire e1fr_pkg::e1fr_sig_type i_sig_bits,
    input wire logic i_sig_en,
    input wire logic i_debounce_en,
    // Line code violation pulse from the receive framer.
    input wire logic i_lcv,
    // Message controller side.
    input wire logic [NUM_CTL-1:0] i_tx_free_buf,
    input wire logic [NUM_CTL-1:0] i_rx_buf_ptr,
    input wire logic [NUM_CTL-1:0] i_rx_done,
    input wire logic i_ctl_buf,
    input wire logic [6:0] i_ctl_addr,
    input wire logic i_ctl_we,
    input wire logic [7:0] i_ctl_wdata,
    output logic [7:0] o_ctl_rdata,
    output logic [1:0] o_ctl_sel,
    output logic o_tx_msg_ready,
    output logic o_tx_msg_buf
);
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.
    ////////////////////////////////////////////////////////////////////////////////

    // Pointer advance that wraps after the last byte of a message.
    function automatic logic [6:0] e1fr_next_ptr(input logic [6:0] ptr);
        e1fr_next_ptr = (ptr == `E1FR_BUF_LAST) ? 7'h00 : ptr + 7'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.
    ////////////////////////////////////////////////////////////////////////////////

    e1fr_pkg::e1fr_sig_type sig_array [NUM_TS]; // Stored entries seen by the host.
    e1fr_pkg::e1fr_sig_type sig_prev [NUM_TS]; // Last superframe sample per timeslot.
    logic [7:0] buf0 [`E1FR_BUF_BYTES]; // Message buffer zero.
    logic [7:0] buf1 [`E1FR_BUF_BYTES]; // Message buffer one.
    logic [6:0] ptr0; // Host byte pointer of buffer zero.
    logic [6:0] ptr1; // Host byte pointer of buffer one.
    logic [1:0] ctl_sel; // Selected message controller.
    logic [15:0] lcv_count; // Running violation count.
    logic [7:0] lcv_hold; // Lower byte frozen by the upper read.
    logic [NUM_CTL-1:0] irq_status; // Sticky end-of-message flags.
    logic [NUM_CTL-1:0] irq_mask; // Enables for the flags.
    logic [7:0] rdata; // Registered read data.

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.
    ////////////////////////////////////////////////////////////////////////////////

    wire hit_sig = (bus.addr >= `E1FR_SIG_BASE) && (bus.addr <= `E1FR_SIG_LAST);
    wire hit_buf0 = (bus.addr == `E1FR_BUF0_PORT);
    wire hit_buf1 = (bus.addr == `E1FR_BUF1_PORT);
    wire hit_lcv_hi = (bus.addr == `E1FR_LCV_UPPER);
    wire hit_lcv_lo = (bus.addr == `E1FR_LCV_LOWER);
    wire hit_sel = (bus.addr == `E1FR_CTL_SELECT);
    wire hit_stat = (bus.addr == `E1FR_IRQ_STATUS);
    wire hit_mask = (bus.addr == `E1FR_IRQ_MASK);
    wire acc0 = (bus.wr || bus.rd) && hit_buf0;
    wire acc1 = (bus.wr || bus.rd) && hit_buf1;
    wire [4:0] sig_idx = bus.addr[4:0];
    wire deb_active = i_sig_en && i_debounce_en;
    wire [NUM_CTL-1:0] stat_clear = (bus.wr && hit_stat) ? bus.wdata[NUM_CTL-1:0] : '0;
    wire lcv_clear = bus.rd && hit_lcv_hi;
    // Transmit and receive byte-count offsets, one pair per controller.
    wire hit_tx_cnt = (bus.addr == `E1FR_TX_COUNT_1) || (bus.addr == `E1FR_TX_COUNT_2)
                      || (bus.addr == `E1FR_TX_COUNT_3);
    wire hit_rx_cnt = (bus.addr == `E1FR_RX_COUNT_1) || (bus.addr == `E1FR_RX_COUNT_2)
                      || (bus.addr == `E1FR_RX_COUNT_3);
    // The count registers of the controllers differ only in bits 7:4 (1, 4, 5); pick its flag from them.
    wire [1:0] cnt_ctl = (bus.addr[7:4] == 4'h1) ? 2'h0 :
                         (bus.addr[7:4] == 4'h4) ? 2'h1 : 2'h2;
    wire tx_flag = i_tx_free_buf[cnt_ctl];
    wire rx_flag = i_rx_buf_ptr[cnt_ctl];

    ////////////////////////////////////////////////////////////////////////////////
    // Read data selection, answered in the cycle after the strobe.
    ////////////////////////////////////////////////////////////////////////////////

    wire [7:0] next_rdata =
        hit_sig ? {4'h0, sig_array[sig_idx]} :
        hit_buf0 ? buf0[ptr0] :
        hit_buf1 ? buf1[ptr1] :
        hit_lcv_hi ? lcv_count[15:8] :
        hit_lcv_lo ? lcv_hold :
        hit_sel ? {6'h00, ctl_sel} :
        hit_tx_cnt ? {tx_flag, 7'h00} :
        hit_rx_cnt ? {rx_flag, 7'h00} :
        hit_stat ? {{(8 - NUM_CTL){1'b0}}, irq_status} :
        hit_mask ? {{(8 - NUM_CTL){1'b0}}, irq_mask} :
        `E1FR_RESET_BYTE;

    // Read data register; unmapped offsets read as zero.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata <= `E1FR_RESET_BYTE;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= `E1FR_RESET_BYTE;
        end
    end
    assign bus.rdata = rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Signaling array.
    ////////////////////////////////////////////////////////////////////////////////

    // The previous sample is kept even without debounce so that enabling it later
    // compares against a real superframe rather than a stale reset value.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            for (int i = 0; i < NUM_TS; i++) begin
                sig_array[i] <= 4'h0;
                sig_prev[i] <= 4'h0;
            end
        end else if (i_sig_valid) begin
            sig_prev[i_sig_ts] <= i_sig_bits;
            if (!deb_active) begin
                sig_array[i_sig_ts] <= i_sig_bits;
            end else if (i_sig_bits == sig_prev[i_sig_ts]) begin
                sig_array[i_sig_ts] <= i_sig_bits;
            end
            // A differing pair of superframes leaves the entry as it is.
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Message buffers and controller selection.
    ////////////////////////////////////////////////////////////////////////////////

    // Byte pointers advance on both reads and writes of a port.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ptr0 <= 7'h00;
            ptr1 <= 7'h00;
            ctl_sel <= 2'h0;
        end else begin
            if (acc0) begin
                ptr0 <= e1fr_next_ptr(ptr0);
            end
            if (acc1) begin
                ptr1 <= e1fr_next_ptr(ptr1);
            end
            // Changing controller restarts both messages at their first byte.
            if (bus.wr && hit_sel) begin
                ctl_sel <= bus.wdata[1:0];
                ptr0 <= 7'h00;
                ptr1 <= 7'h00;
            end
        end
    end

    // Buffer contents; the host port wins over a controller write to the same buffer,
    // which a controller should never attempt while the host owns that buffer.
    always_ff @(posedge i_sys_clk) begin
        if (bus.wr && hit_buf0) begin
            buf0[ptr0] <= bus.wdata;
        end else if (i_ctl_we && !i_ctl_buf) begin
            buf0[i_ctl_addr] <= i_ctl_wdata;
        end
        if (bus.wr && hit_buf1) begin
            buf1[ptr1] <= bus.wdata;
        end else if (i_ctl_we && i_ctl_buf) begin
            buf1[i_ctl_addr] <= i_ctl_wdata;
        end
    end

    // Controller read port and the hand-over pulse when the last byte is written.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_ctl_rdata <= `E1FR_RESET_BYTE;
            o_tx_msg_ready <= 1'b0;
            o_tx_msg_buf <= 1'b0;
        end else begin
            o_ctl_rdata <= i_ctl_buf ? buf1[i_ctl_addr] : buf0[i_ctl_addr];
            o_tx_msg_ready <= 1'b0;
            if (bus.wr && hit_buf0 && ptr0 == `E1FR_BUF_LAST) begin
                o_tx_msg_ready <= 1'b1;
                o_tx_msg_buf <= 1'b0;
            end else if (bus.wr && hit_buf1 && ptr1 == `E1FR_BUF_LAST) begin
                o_tx_msg_ready <= 1'b1;
                o_tx_msg_buf <= 1'b1;
            end
        end
    end
    assign o_ctl_sel = ctl_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // Line code violation counter.
    ////////////////////////////////////////////////////////////////////////////////

    // Reading the upper byte clears the count and freezes the lower byte; a violation
    // in that same cycle becomes the first count of the new interval.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            lcv_count <= 16'h0000;
            lcv_hold <= `E1FR_RESET_BYTE;
        end else if (lcv_clear) begin
            lcv_hold <= lcv_count[7:0];
            lcv_count <= {15'h0000, i_lcv};
        end else if (i_lcv && lcv_count != 16'hFFFF) begin
            lcv_count <= lcv_count + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts.
    ////////////////////////////////////////////////////////////////////////////////

    // Sticky flags, cleared by writing one; a new event beats a clear in one cycle.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            irq_status <= (irq_status & ~stat_clear) | i_rx_done;
            if (bus.wr && hit_mask) begin
                irq_mask <= bus.wdata[NUM_CTL-1:0];
            end
        end
    end
    assign bus.irq = |(irq_status & irq_mask);
endmodule

// File: rtl/e1fr_host.sv
// Host end: drives the register bus and reads sixteen-bit counters in order.
`timescale 1ns/100ps
module e1fr_host (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register bus toward the channel.
    e1fr_bus_if.host bus,
    // Command port from software.
    input wire logic i_cmd_wr,
    input wire logic i_cmd_rd,
    input wire logic i_cmd_cnt16,
    input wire logic [11:0] i_cmd_addr,
    input wire logic [7:0] i_cmd_wdata,
    // Answers toward software.
    output logic o_busy,
    output logic o_rsp_valid,
    output logic [15:0] o_rsp_data,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // State.
    ////////////////////////////////////////////////////////////////////////////////

    e1fr_pkg::e1fr_host_state_type state; // Counter read sequencer.
    e1fr_pkg::e1fr_host_state_type next_state; // Its next value.
    logic [11:0] addr; // Bus address register.
    logic [7:0] wdata; // Bus write data register.
    logic wr; // Bus write strobe register.
    logic rd; // Bus read strobe register.
    logic plain_rd_wait; // A single-byte read awaits its data.
    logic [7:0] hi_byte; // Upper byte captured during a counter read.

    wire idle = (state == e1fr_pkg::E1FR_IDLE);
    wire take_cnt = idle && i_cmd_cnt16;
    wire take_rd = idle && !i_cmd_cnt16 && i_cmd_rd;
    wire take_wr = idle && !i_cmd_cnt16 && !i_cmd_rd && i_cmd_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: upper byte first, then the lower byte at the next offset.
    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_state = state;
        case (state)
            e1fr_pkg::E1FR_IDLE: begin
                if (i_cmd_cnt16) begin
                    next_state = e1fr_pkg::E1FR_RD_HI;
                end
            end
            e1fr_pkg::E1FR_RD_HI: begin
                next_state = e1fr_pkg::E1FR_RD_LO;
            end
            e1fr_pkg::E1FR_RD_LO: begin
                next_state = e1fr_pkg::E1FR_DONE;
            end
            default: begin
                next_state = e1fr_pkg::E1FR_IDLE;
            end
        endcase
    end

    // Bus master registers; strobes last one cycle.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state <= e1fr_pkg::E1FR_IDLE;
            addr <= 12'h000;
            wdata <= 8'h00;
            wr <= 1'b0;
            rd <= 1'b0;
        end else begin
            state <= next_state;
            wr <= take_wr;
            rd <= take_rd || take_cnt || (state == e1fr_pkg::E1FR_RD_HI);
            if (take_cnt || take_rd || take_wr) begin
                addr <= i_cmd_addr;
                wdata <= i_cmd_wdata;
            end else if (state == e1fr_pkg::E1FR_RD_HI) begin
                addr <= addr + 12'h001;
            end
        end
    end

    // Answer capture: a plain read returns one byte, a counter read returns both.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            plain_rd_wait <= 1'b0;
            hi_byte <= 8'h00;
            o_rsp_valid <= 1'b0;
            o_rsp_data <= 16'h0000;
        end else begin
            // Data stand the cycle after the strobe.
            plain_rd_wait <= rd && idle;
            o_rsp_valid <= 1'b0;
            if (plain_rd_wait) begin
                o_rsp_valid <= 1'b1;
                o_rsp_data <= {8'h00, bus.rdata};
            end
            if (state == e1fr_pkg::E1FR_RD_LO) begin
                hi_byte <= bus.rdata;
            end
            if (state == e1fr_pkg::E1FR_DONE) begin
                o_rsp_valid <= 1'b1;
                o_rsp_data <= {hi_byte, bus.rdata};
            end
        end
    end

    assign bus.addr = addr;
    assign bus.wdata = wdata;
    assign bus.wr = wr;
    assign bus.rd = rd;
    assign o_busy = !idle;
    assign o_irq = bus.irq;
endmodule

// File: bench/e1fr_regs_sva.sv
// Bus-side assertions for the joined host and framer channel ends.
`timescale 1ns/100ps
module e1fr_regs_sva (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register bus signals.
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of both buffers; only bytes already written may be read back.
    logic [7:0] m0 [0:95];
    logic [7:0] m1 [0:95];
    logic [6:0] p0; // Shadow pointer of buffer zero.
    logic [6:0] p1; // Shadow pointer of buffer one.
    logic [7:0] exp0; // Byte that a read of buffer zero must return.
    logic [7:0] exp1; // Byte that a read of buffer one must return.
    logic [7:0] mask_q; // Shadow of the interrupt mask.
    wire sel_wr = wr && (addr == 12'h11B);
    wire b0_acc = (wr || rd) && (addr == 12'h600);
    wire b1_acc = (wr || rd) && (addr == 12'h700);
    wire [6:0] next_p0 = (p0 == 7'h5F) ? 7'h00 : p0 + 7'h01;
    wire [6:0] next_p1 = (p1 == 7'h5F) ? 7'h00 : p1 + 7'h01;
    // Pointers wrap after the last byte and restart on a select write.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || sel_wr) begin
            p0 <= 7'h00;
            p1 <= 7'h00;
        end else begin
            p0 <= b0_acc ? next_p0 : p0;
            p1 <= b1_acc ? next_p1 : p1;
        end
    end
    // Contents are not reset, so the shadow keeps no reset either.
    always_ff @(posedge i_sys_clk) begin
        if (wr && b0_acc) m0[p0] <= wdata;
        if (wr && b1_acc) m1[p1] <= wdata;
        exp0 <= m0[p0];
        exp1 <= m1[p1];
    end
    // Mask shadow follows every mask write.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) mask_q <= 8'h00;
        else if (wr && (addr == 12'hB01)) mask_q <= wdata;
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence up_rd_s; rd && (addr == 12'h900); endsequence
    sequence lo_rd_s; rd && (addr == 12'h901); endsequence
    sequence b0_rd_s; rd && (addr == 12'h600); endsequence
    sequence b1_rd_s; rd && (addr == 12'h700); endsequence
    sig_upper_zero_a: assert property (rd && addr >= 12'h500 && addr <= 12'h51F |=>
        rdata[7:4] == 4'h0) else $error("signaling entry upper bits not zero");
    buf_zero_data_a: assert property (b0_rd_s |=> rdata == exp0)
        else $error("buffer zero byte out of order");
    buf_one_data_a: assert property (b1_rd_s |=> rdata == exp1)
        else $error("buffer one byte out of order");
    cnt_pair_a: assert property (up_rd_s |=> lo_rd_s)
        else $error("upper counter read not followed by lower read");
    irq_masked_a: assert property (wr && addr == 12'hB01 && wdata[2:0] == 3'h0 |=> !irq)
        else $error("interrupt high with all bits masked");
    irq_needs_mask_a: assert property (irq |-> mask_q[2:0] != 3'h0)
        else $error("interrupt without an enabled mask bit");
    irq_status_a: assert property (rd && addr == 12'hB00 |=>
        irq == |(rdata[2:0] & mask_q[2:0])) else $error("interrupt disagrees with status");
    read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its one cycle");
endmodule

// File: bench/tb_e1_framer_rx_signaling_lapd_performance_monitor_regs.sv
// Testbench joining host and channel ends through the register bus.
`timescale 1ns/100ps
`define CHK(nm, e, g) n_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end
module tb_e1_framer_rx_signaling_lapd_performance_monitor_regs;
    // Clock, reset and host command port.
    logic i_sys_clk, i_rst, i_cmd_wr, i_cmd_rd, i_cmd_cnt16;
    logic [11:0] i_cmd_addr;
    logic [7:0] i_cmd_wdata;
    logic o_busy, o_rsp_valid, o_irq, i_sig_valid, i_sig_en, i_debounce_en, i_lcv;
    logic [15:0] o_rsp_data;
    // Framer and message controller side.
    logic [4:0] i_sig_ts;
    logic [3:0] i_sig_bits;
    logic [2:0] i_tx_free_buf, i_rx_buf_ptr, i_rx_done;
    logic i_ctl_buf, i_ctl_we, o_tx_msg_ready, o_tx_msg_buf;
    logic [6:0] i_ctl_addr;
    logic [7:0] i_ctl_wdata, o_ctl_rdata;
    logic [1:0] o_ctl_sel;
    logic [31:0] seed = 32'h2D82; // Fixed seed keeps runs repeatable.
    int fails = 0;
    int n_checks = 0;
    int n_ready = 0; // Transmit hand-over pulses seen.
    logic [31:0] expq [$]; // Compare mask in the upper half, value in the lower.
    logic [7:0] mem [0:95];
    e1fr_bus_if bus_if ();
    e1fr_channel u_e1fr_channel (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .bus(bus_if),
        .i_sig_valid(i_sig_valid), .i_sig_ts(i_sig_ts), .i_sig_bits(i_sig_bits),
        .i_sig_en(i_sig_en), .i_debounce_en(i_debounce_en), .i_lcv(i_lcv),
        .i_tx_free_buf(i_tx_free_buf), .i_rx_buf_ptr(i_rx_buf_ptr), .i_rx_done(i_rx_done),
        .i_ctl_buf(i_ctl_buf), .i_ctl_addr(i_ctl_addr), .i_ctl_we(i_ctl_we),
        .i_ctl_wdata(i_ctl_wdata), .o_ctl_rdata(o_ctl_rdata), .o_ctl_sel(o_ctl_sel),
        .o_tx_msg_ready(o_tx_msg_ready), .o_tx_msg_buf(o_tx_msg_buf));
    e1fr_host u_e1fr_host (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .bus(bus_if),
        .i_cmd_wr(i_cmd_wr), .i_cmd_rd(i_cmd_rd), .i_cmd_cnt16(i_cmd_cnt16),
        .i_cmd_addr(i_cmd_addr), .i_cmd_wdata(i_cmd_wdata), .o_busy(o_busy),
        .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_irq(o_irq));
    e1fr_regs_sva u_e1fr_regs_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
        .rdata(bus_if.rdata), .irq(bus_if.irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 100 MHz clock.
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // Xorshift step; the low byte feeds the stimulus.
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // One command pulse; waits first while a counter read holds the host busy.
    task automatic cmd(input logic [2:0] k, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        #1;
        while (o_busy !== 1'b0 && n < 50) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        if (n == 50) fails++;
        @(posedge i_sys_clk);
        {i_cmd_cnt16, i_cmd_rd, i_cmd_wr} <= k;
        i_cmd_addr <= a;
        i_cmd_wdata <= d;
        @(posedge i_sys_clk);
        {i_cmd_cnt16, i_cmd_rd, i_cmd_wr} <= 3'h0;
    endtask
    // Read command whose answer is noted for the monitor.
    task automatic rdq(input logic [2:0] k, input logic [11:0] a, input logic [15:0] m,
                       input logic [15:0] e);
        expq.push_back({m, e});
        cmd(k, a, 8'h00);
    endtask
    // One signaling sample from the framer.
    task automatic sig(input logic [4:0] t, input logic [3:0] v);
        @(posedge i_sys_clk);
        i_sig_valid <= 1'b1;
        i_sig_ts <= t;
        i_sig_bits <= v;
        @(posedge i_sys_clk);
        i_sig_valid <= 1'b0;
    endtask
    // Lets a written command reach the channel before its effect is looked at.
    task automatic settle();
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic results();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Answers are compared at the falling edge, where registered outputs are settled.
    always @(negedge i_sys_clk) begin : mon
        logic [31:0] e;
        if (o_rsp_valid === 1'b1) begin
            if (expq.size() == 0) e = 32'hFFFF_0000 ^ {16'h0, ~o_rsp_data};
            else e = expq.pop_front();
            `CHK("answer", e[15:0], o_rsp_data & e[31:16])
        end
        if (o_tx_msg_ready === 1'b1) n_ready++;
    end
    // Watchdog sized well above the fewer than two thousand cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fails++;
        results();
    end
    initial begin
        int i, bf, n;
        logic [7:0] b;
        logic [11:0] ta [3];
        logic [11:0] ra [3];
        ta = '{12'h114, 12'h144, 12'h154};
        ra = '{12'h115, 12'h145, 12'h155};
        {i_cmd_wr, i_cmd_rd, i_cmd_cnt16, i_sig_valid, i_sig_en, i_debounce_en} = 6'h00;
        {i_lcv, i_ctl_buf, i_ctl_we, i_sig_ts, i_sig_bits} = 12'h000;
        {i_tx_free_buf, i_rx_buf_ptr, i_rx_done, i_ctl_addr} = 16'h0000;
        {i_cmd_addr, i_cmd_wdata, i_ctl_wdata} = 28'h0;
        i_rst = 1'b1;
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rdq(3'h2, 12'h500, 16'h00FF, 16'h0000);
        // Every timeslot entry follows its sample while debounce is off.
        for (i = 0; i < 32; i++) begin
            b = rnd();
            sig(i[4:0], b[3:0]);
            rdq(3'h2, 12'h500 + i[11:0], 16'h00FF, {12'h000, b[3:0]});
        end
        cmd(3'h1, 12'h51F, 8'hFF);
        rdq(3'h2, 12'h51F, 16'h00FF, {12'h000, b[3:0]});
        i_sig_en <= 1'b1;
        i_debounce_en <= 1'b1;
        sig(5'h1F, ~b[3:0]);
        rdq(3'h2, 12'h51F, 16'h00FF, {12'h000, b[3:0]});
        sig(5'h1F, ~b[3:0]);
        rdq(3'h2, 12'h51F, 16'h00FF, {12'h000, ~b[3:0]});
        i_sig_en <= 1'b0;
        sig(5'h1F, b[3:0]);
        rdq(3'h2, 12'h51F, 16'h00FF, {12'h000, b[3:0]});
        // Fill each buffer, hand it over, then read it back past the wrap.
        for (bf = 0; bf < 2; bf++) begin
            cmd(3'h1, 12'h11B, bf[7:0] + 8'h01);
            settle();
            `CHK("select", bf[1:0] + 2'h1, o_ctl_sel)
            for (i = 0; i < 96; i++) begin
                mem[i] = rnd();
                cmd(3'h1, bf ? 12'h700 : 12'h600, mem[i]);
            end
            settle();
            `CHK("ready count", bf + 1, n_ready)
            `CHK("ready buffer", bf[0], o_tx_msg_buf)
            i_ctl_buf <= bf[0];
            i_ctl_addr <= 7'h03;
            settle();
            `CHK("controller byte", mem[3], o_ctl_rdata)
            cmd(3'h1, 12'h11B, bf[7:0] + 8'h01);
            for (i = 0; i < 97; i++) begin
                rdq(3'h2, bf ? 12'h700 : 12'h600, 16'h00FF, {8'h00, mem[i % 96]});
            end
        end
        // Buffer flags of each controller.
        b = rnd();
        i_tx_free_buf <= b[2:0];
        i_rx_buf_ptr <= b[5:3];
        for (i = 0; i < 3; i++) begin
            rdq(3'h2, ta[i], 16'h0080, {8'h00, b[i], 7'h00});
            rdq(3'h2, ra[i], 16'h0080, {8'h00, b[i + 3], 7'h00});
        end
        // Receive completion raises, masks and clears the interrupt.
        cmd(3'h1, 12'hB01, 8'h07);
        i_rx_done <= 3'h2;
        @(posedge i_sys_clk);
        i_rx_done <= 3'h0;
        settle();
        `CHK("irq raised", 1'b1, o_irq)
        rdq(3'h2, 12'hB00, 16'h00FF, 16'h0002);
        cmd(3'h1, 12'hB01, 8'h00);
        settle();
        `CHK("irq masked", 1'b0, o_irq)
        cmd(3'h1, 12'hB01, 8'h07);
        settle();
        `CHK("irq unmasked", 1'b1, o_irq)
        cmd(3'h1, 12'hB00, 8'h02);
        settle();
        `CHK("irq cleared", 1'b0, o_irq)
        rdq(3'h2, 12'hB00, 16'h00FF, 16'h0000);
        // Violation count read upper first, then cleared by that read.
        n = 256 + rnd();
        i_lcv <= 1'b1;
        repeat (n) @(posedge i_sys_clk);
        i_lcv <= 1'b0;
        rdq(3'h4, 12'h900, 16'hFFFF, n[15:0]);
        rdq(3'h4, 12'h900, 16'hFFFF, 16'h0000);
        n = 0;
        while (expq.size() > 0 && n < 100) begin
            @(posedge i_sys_clk);
            n++;
        end
        if (expq.size() > 0) fails++;
        settle();
        results();
    end
endmodule
